// File: core/fsa_pkg.sv
// Package: register map, field positions and timing constants of the frame sync aligner
package fsa_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_ALIGN  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // CONFIG fields
  localparam int CFG_SYNC_LEN   = 0;
  localparam int CFG_VCO_INV    = 1;
  localparam int CFG_EDGE_SEL   = 2;
  localparam int CFG_REFLECT    = 3;
  localparam int CFG_SIDE_EN    = 4;
  localparam int CFG_USE_SYNCO  = 5;
  localparam int CFG_DRAIN_EN   = 6;
  localparam int CFG_REARM      = 7;
  localparam int CFG_RX_SEL_LO  = 8;
  localparam int CFG_TX_SEL_LO  = 10;
  localparam logic [11:0] CFG_RESET = 12'h040;
  localparam logic [11:0] CFG_MASK  = 12'hf7f;

  // ALIGN fields
  localparam int ALN_FRAME_LO = 0;
  localparam int ALN_MFN_LO   = 8;
  localparam int ALN_PHASE_LO = 24;
  localparam logic [31:0] ALN_RESET = 32'h0000_0000;

  // STATUS fields
  localparam int ST_LOCKED  = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_PHASE   = 2;
  localparam int ST_FILL    = 4;
  localparam int ST_POS     = 8;
  localparam int ST_FRAME   = 16;

  // Bypass selections for each PCM output
  localparam logic [1:0] SEL_NORMAL  = 2'h0;
  localparam logic [1:0] SEL_RECEIVE = 2'h1;
  localparam logic [1:0] SEL_SEND    = 2'h2;

  // ----------------------------------------------------------------
  // Framing and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_OUT    = 2'h0;
  localparam logic [1:0] PHASE_SAMPLE = 2'h2;
  localparam logic [1:0] PHASE_LAST   = 2'h3;
  localparam logic [7:0] POS_LAST     = 8'hff;
  localparam logic [4:0] FRAME_LAST   = 5'h1f;
  localparam logic [2:0] CHAN0_LAST_BIT = 3'h7;
  localparam int CLOCK_SYNC_HOLD = 16;
  localparam int SCLK_DIV        = 4;
  localparam int SCLKO_DELAY     = 3;
endpackage : fsa_pkg

// File: core/fsa_sync2.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module fsa_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= pinIn;
      syncOut  <= stage1_q;
    end
  end
endmodule : fsa_sync2

// File: core/fsa_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module fsa_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 4
) (
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [W-1:0]             inData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [W-1:0]                  outData,
  output logic [$clog2(DEPTH+1)-1:0]    fill
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [$clog2(DEPTH+1)-1:0] FILL_FULL = ($clog2(DEPTH+1))'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic          push;
  logic          pop;

  assign inReady  = (fill != FILL_FULL);
  assign outValid = (fill != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      fill    <= '0;
    end else begin
      if (push) wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + 1'b1;
      if (pop)  rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + 1'b1;
      if (push && !pop) fill <= fill + 1'b1;
      else if (pop && !push) fill <= fill - 1'b1;
    end
  end
endmodule : fsa_fifo

// File: core/fsa_align.sv
// Frame sync, side-channel alignment, VCO phase detector and PCM bypass
`timescale 1ns/100ps
module fsa_align
  import fsa_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        systemClockIn,
  input  wire logic        fastOperatingClock,
  input  wire logic        fastClockSelectPin,
  input  wire logic        frameSyncIn_n,
  input  wire logic        receivePcmIn,
  input  wire logic        sendPcmIn,
  input  wire logic        sideChannelIn,
  output logic             receivePcmOut,
  output logic             sendPcmOut,
  output logic             sideChannelOut,
  output logic             sideChannelTrackOut,
  output logic             frameSyncOut_n,
  output logic             vcoControlOut,
  output logic             systemClockOut,
  output logic             clockSyncOut
);
  localparam int FW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge events
  // ----------------------------------------------------------------
  logic [6:0] pinSync;
  logic       sclkS, fastS, selS, fsInS, rxS, txS, sideS;
  logic       sclkPrev_q, fastPrev_q;
  logic       sclkFall, sclkRise, fastRise;

  // Frame sync enters inverted so that the reset value of its stages means no sync
  fsa_sync2 #(.W(7)) uSync (
    .clock   (clock),
    .reset_n (reset_n),
    .pinIn   ({systemClockIn, fastOperatingClock, fastClockSelectPin, ~frameSyncIn_n,
                receivePcmIn, sendPcmIn, sideChannelIn}),
    .syncOut (pinSync)
  );
  assign {sclkS, fastS, selS, fsInS, rxS, txS, sideS} = pinSync;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_q <= 1'b0;
      fastPrev_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkS;
      fastPrev_q <= fastS;
    end
  end
  assign sclkFall = sclkPrev_q && !sclkS;
  assign sclkRise = !sclkPrev_q && sclkS;
  assign fastRise = !fastPrev_q && fastS;

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [11:0] cfg_q;
  logic [31:0] align_q;
  logic        overrun_q, locked_q;
  logic [1:0]  phase_q, phaseD;
  logic [7:0]  pos_q, posD;
  logic [4:0]  frame_q, frameD;
  logic [FW-1:0] fill;
  logic        apbAccess, apbWrite, mapped, rearm, overrunSet;

  assign apbAccess = psel && penable && !pready;
  assign apbWrite  = apbAccess && pwrite;
  assign mapped    = (paddr == ADDR_CONFIG) || (paddr == ADDR_ALIGN) || (paddr == ADDR_STATUS);
  assign rearm     = apbWrite && (paddr == ADDR_CONFIG) && pwdata[CFG_REARM];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q   <= CFG_RESET;
      align_q <= ALN_RESET;
    end else if (apbWrite) begin
      if (paddr == ADDR_CONFIG) cfg_q   <= pwdata[11:0] & CFG_MASK;
      if (paddr == ADDR_ALIGN)  align_q <= pwdata;
    end
  end

  // Write-one-to-clear; a new overrun in the same cycle wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) overrun_q <= 1'b0;
    else if (overrunSet) overrun_q <= 1'b1;
    else if (apbWrite && (paddr == ADDR_STATUS) && pwdata[ST_OVERRUN]) overrun_q <= 1'b0;
  end

  // One wait state on every access
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apbAccess;
      pslverr <= apbAccess && !mapped;
      prdata  <= '0;
      if (apbAccess && !pwrite) begin
        case (paddr)
          ADDR_CONFIG: prdata <= {20'h0_0000, cfg_q};
          ADDR_ALIGN:  prdata <= align_q;
          ADDR_STATUS: begin
            prdata[ST_LOCKED]               <= locked_q;
            prdata[ST_OVERRUN]              <= overrun_q;
            prdata[ST_PHASE +: 2]           <= phase_q;
            prdata[ST_FILL +: FW]           <= fill;
            prdata[ST_POS +: 8]             <= pos_q;
            prdata[ST_FRAME +: 5]           <= frame_q;
          end
          default:     prdata <= '0;
        endcase
      end
    end
  end

  logic       syncLen2, vcoInv, edgeSel, reflect, sideEn, useSyncOut, drainEn;
  logic [1:0] rxSel, txSel;
  logic [7:0] frameOffset;
  logic [4:0] mfNumber;
  logic [1:0] phaseOffset;
  assign syncLen2    = cfg_q[CFG_SYNC_LEN];
  assign vcoInv      = cfg_q[CFG_VCO_INV];
  assign edgeSel     = cfg_q[CFG_EDGE_SEL];
  assign reflect     = cfg_q[CFG_REFLECT];
  assign sideEn      = cfg_q[CFG_SIDE_EN];
  assign useSyncOut  = cfg_q[CFG_USE_SYNCO];
  assign drainEn     = cfg_q[CFG_DRAIN_EN];
  assign rxSel       = cfg_q[CFG_RX_SEL_LO +: 2];
  assign txSel       = cfg_q[CFG_TX_SEL_LO +: 2];
  assign frameOffset = align_q[ALN_FRAME_LO +: 8];
  assign mfNumber    = align_q[ALN_MFN_LO +: 5];
  assign phaseOffset = align_q[ALN_PHASE_LO + 6 +: 2];

  // ----------------------------------------------------------------
  // Clock loop: divider, phase detector, monitor, clock sync pulse
  // ----------------------------------------------------------------
  logic [1:0] div_q;
  logic [SCLKO_DELAY-1:0] dly_q;
  logic [4:0] holdCnt_q;
  logic       vcoOut_q, sysOut_q, clkSync_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      dly_q <= '0;
    end else if (fastRise) begin
      div_q <= div_q + 1'b1;
      dly_q <= {dly_q[SCLKO_DELAY-2:0], div_q[1]};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vcoOut_q <= 1'b0;
      sysOut_q <= 1'b0;
    end else begin
      vcoOut_q <= sclkS ^ div_q[1] ^ vcoInv;
      sysOut_q <= selS && dly_q[SCLKO_DELAY-1];
    end
  end

  logic frameStart;
  // Pulse starts at frame start and changes only on fast clock rises
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkSync_q <= 1'b0;
      holdCnt_q <= '0;
    end else if (fastRise) begin
      if (frameStart && !clkSync_q) begin
        clkSync_q <= 1'b1;
        holdCnt_q <= '0;
      end else if (clkSync_q) begin
        holdCnt_q <= holdCnt_q + 1'b1;
        if (holdCnt_q == 5'(CLOCK_SYNC_HOLD - 1)) clkSync_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync detection and bit/frame counters
  // ----------------------------------------------------------------
  logic pend_q, fsOut_n_q, fsLen_q, syncActive, syncPoint;

  // Own sync may stand in only while the side channel is off
  assign syncActive = (useSyncOut && !sideEn) ? !fsOut_n_q : fsInS;
  assign syncPoint  = sclkFall && (edgeSel ? pend_q : syncActive);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) pend_q <= 1'b0;
    else if (sclkRise) pend_q <= edgeSel && syncActive;
    else if (sclkFall) pend_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) locked_q <= 1'b0;
    else if (syncPoint) locked_q <= 1'b1;
    else if (rearm) locked_q <= 1'b0;
  end

  // Values after the coming falling edge: four phases per bit
  always_comb begin
    phaseD = phase_q + 1'b1;
    posD   = (phase_q == PHASE_LAST) ? pos_q + 1'b1 : pos_q;
    frameD = (phase_q == PHASE_LAST && pos_q == POS_LAST) ? frame_q + 1'b1 : frame_q;
    if (syncPoint && !locked_q) begin
      phaseD = phaseOffset;
      posD   = frameOffset;
      frameD = (frameOffset == '0 && phaseOffset == PHASE_OUT) ? mfNumber : mfNumber - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= '0;
      pos_q   <= '0;
      frame_q <= '0;
    end else if (sclkFall) begin
      phase_q <= phaseD;
      pos_q   <= posD;
      frame_q <= frameD;
    end
  end

  assign frameStart = (phase_q == PHASE_OUT) && (pos_q == '0);

  // Outgoing frame sync, low for one or two system clock periods
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fsOut_n_q <= 1'b1;
      fsLen_q   <= 1'b0;
    end else if (sclkFall) begin
      if (phaseD == PHASE_OUT && posD == '0) begin
        fsOut_n_q <= 1'b0;
        fsLen_q   <= syncLen2;
      end else if (fsLen_q) begin
        fsLen_q <= 1'b0;
      end else begin
        fsOut_n_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data: sampling, buffering, output
  // ----------------------------------------------------------------
  logic samplePt, outputPt, pushSide, fifoReady, fifoValid, fifoData;
  logic rxSample_q, txSample_q, rxOut_q, txOut_q, sideOut_q, trackOut_q;

  assign samplePt = sclkFall && (phaseD == PHASE_SAMPLE);
  assign outputPt = sclkFall && (phaseD == PHASE_OUT);
  assign pushSide = samplePt && sideEn && locked_q;
  assign overrunSet = pushSide && !fifoReady;

  fsa_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) uFifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .inValid  (pushSide),
    .inReady  (fifoReady),
    .inData   (sideS),
    .outValid (fifoValid),
    .outReady (outputPt && drainEn),
    .outData  (fifoData),
    .fill     (fill)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxSample_q <= 1'b0;
      txSample_q <= 1'b0;
    end else if (samplePt) begin
      rxSample_q <= rxS;
      txSample_q <= txS;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxOut_q    <= 1'b0;
      txOut_q    <= 1'b0;
      sideOut_q  <= 1'b0;
      trackOut_q <= 1'b0;
    end else if (outputPt) begin
      rxOut_q    <= rxSample_q;
      txOut_q    <= txSample_q;
      trackOut_q <= locked_q && (frameD == '0) && (posD[7:3] == '0);
      if (drainEn && fifoValid) sideOut_q <= fifoData;
    end
  end

  // Bypass and reflect paths are combinational from the pins
  function automatic logic pcmMux(input logic [1:0] sel, input logic own, input logic rx, input logic tx);
    pcmMux = (sel == SEL_RECEIVE) ? rx : (sel == SEL_SEND) ? tx : own;
  endfunction : pcmMux

  assign receivePcmOut       = pcmMux(rxSel, rxOut_q, receivePcmIn, sendPcmIn);
  assign sendPcmOut          = pcmMux(txSel, txOut_q, receivePcmIn, sendPcmIn);
  assign sideChannelOut      = reflect ? sideChannelIn : sideOut_q;
  assign sideChannelTrackOut = trackOut_q;
  assign frameSyncOut_n      = fsOut_n_q;
  assign vcoControlOut       = vcoOut_q;
  assign systemClockOut      = sysOut_q;
  assign clockSyncOut        = clkSync_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [1:0] lowFalls_q;
  logic       lenTwo_q;
  // Length chosen when the pulse began, so a later config write cannot confuse the check
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lowFalls_q <= '0;
      lenTwo_q   <= 1'b0;
    end else if ($fell(fsOut_n_q)) begin
      lowFalls_q <= '0;
      lenTwo_q   <= fsLen_q;
    end else if (!fsOut_n_q && sclkFall) begin
      lowFalls_q <= lowFalls_q + 1'b1;
    end
  end

  a_sync_out_len: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(fsOut_n_q) |-> lowFalls_q == (lenTwo_q ? 2'h2 : 2'h1))
    else $error("outgoing frame sync width wrong");
  a_vco_phase_det: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> vcoOut_q == ($past(sclkS) ^ $past(div_q[1]) ^ $past(vcoInv)))
    else $error("vco output is not the xor of clocks");
  a_vco_invert: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(vcoInv) && $stable(sclkS) && $stable(div_q) |=> vcoOut_q != $past(vcoOut_q))
    else $error("vco inversion had no effect");
  a_sysclk_monitor: assert property (@(posedge clock) disable iff (!reset_n)
    !selS |=> !sysOut_q)
    else $error("system clock output active without select");
  a_first_sync_load: assert property (@(posedge clock) disable iff (!reset_n)
    syncPoint && !locked_q |=> locked_q && pos_q == $past(frameOffset) && phase_q == $past(phaseOffset))
    else $error("alignment offsets not loaded at first sync");
  a_sample_phase: assert property (@(posedge clock) disable iff (!reset_n)
    pushSide |=> phase_q == PHASE_SAMPLE)
    else $error("side channel sampled outside phase two");
  a_output_phase: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(sideOut_q) |-> phase_q == PHASE_OUT && $past(sclkFall))
    else $error("side channel output changed outside phase zero");
  a_mf_number: assert property (@(posedge clock) disable iff (!reset_n)
    syncPoint && !locked_q && frameOffset != '0 |=> frame_q + 1'b1 == $past(mfNumber))
    else $error("multiframe number not referenced to next frame");
  a_bypass_route: assert property (@(posedge clock) disable iff (!reset_n)
    rxSel == SEL_SEND |-> receivePcmOut == sendPcmIn)
    else $error("send to receive bypass broken");
  a_reflect_path: assert property (@(posedge clock) disable iff (!reset_n)
    reflect |-> sideChannelOut == sideChannelIn)
    else $error("reflect path broken");
  a_clk_sync_hold: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(clkSync_q) |-> $past(holdCnt_q) == 5'(CLOCK_SYNC_HOLD - 1) && $past(fastRise))
    else $error("clock sync pulse too short");
endmodule : fsa_align

// File: sim/fsa_framer_model.sv
// Framer model: locked clocks, frame sync on request and serial data
`timescale 1ns/100ps
module fsa_framer_model (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic syncReq,
  output logic      systemClockIn,
  output logic      fastOperatingClock,
  output logic      frameSyncIn_n,
  output logic      receivePcmIn,
  output logic      sendPcmIn,
  output logic      sideChannelIn
);
  logic [9:0] cnt_q;
  logic       pend_q;
  logic [3:0] low_q;
  // Both clocks come from one counter, so they stay locked in phase
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      cnt_q <= 10'h000;
    else
      cnt_q <= cnt_q + 10'h001;
  end
  assign fastOperatingClock = cnt_q[0];
  assign systemClockIn      = ~cnt_q[2];
  // Each bit spans four system clock periods
  assign receivePcmIn  = cnt_q[5] ^ cnt_q[8];
  assign sendPcmIn     = cnt_q[6] ^ cnt_q[9];
  assign sideChannelIn = cnt_q[7] ^ cnt_q[5];
  // One sync pulse per requested multiframe, spanning a fall and a rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
      low_q  <= 4'h0;
    end else if (syncReq) begin
      pend_q <= 1'b1;
    end else if (pend_q && cnt_q[2:0] == 3'h1) begin
      pend_q <= 1'b0;
      low_q  <= 4'h8;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end
  assign frameSyncIn_n = (low_q == 4'h0);
endmodule : fsa_framer_model

// File: sim/tb_fsa_align.sv
// Testbench for the frame sync aligner
`timescale 1ns/100ps
module tb_fsa_align;
  import fsa_pkg::*;
  logic        clock, reset_n, psel, penable, pwrite, syncReq, fastClockSelectPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, systemClockIn, fastOperatingClock, frameSyncIn_n;
  logic        receivePcmIn, sendPcmIn, sideChannelIn, receivePcmOut, sendPcmOut;
  logic        sideChannelOut, sideChannelTrackOut, frameSyncOut_n, vcoControlOut;
  logic        systemClockOut, clockSyncOut;
  int          nFail, compares;

  fsa_align #(.FIFO_DEPTH(4)) uut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .systemClockIn(systemClockIn), .fastOperatingClock(fastOperatingClock),
    .fastClockSelectPin(fastClockSelectPin), .frameSyncIn_n(frameSyncIn_n), .receivePcmIn(receivePcmIn),
    .sendPcmIn(sendPcmIn), .sideChannelIn(sideChannelIn), .receivePcmOut(receivePcmOut),
    .sendPcmOut(sendPcmOut), .sideChannelOut(sideChannelOut), .sideChannelTrackOut(sideChannelTrackOut),
    .frameSyncOut_n(frameSyncOut_n), .vcoControlOut(vcoControlOut), .systemClockOut(systemClockOut),
    .clockSyncOut(clockSyncOut));
  fsa_framer_model framer (.clock(clock), .reset_n(reset_n), .syncReq(syncReq),
    .systemClockIn(systemClockIn), .fastOperatingClock(fastOperatingClock), .frameSyncIn_n(frameSyncIn_n),
    .receivePcmIn(receivePcmIn), .sendPcmIn(sendPcmIn), .sideChannelIn(sideChannelIn));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chkBit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chkBit
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, ADDR_CONFIG, 32'h0, q, e);
    chk32(q, {20'h0, CFG_RESET});
    apb(1'b0, ADDR_ALIGN, 32'h0, q, e);
    chk32(q, ALN_RESET);
    apb(1'b1, ADDR_ALIGN, 32'hc000_1f5a, q, e);
    apb(1'b0, ADDR_ALIGN, 32'h0, q, e);
    chk32(q, 32'hc000_1f5a);
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk32(q, 32'h0);
    chkBit(e, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_bypass;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CONFIG, 32'h40 | (32'(i[0] ? SEL_SEND : SEL_RECEIVE) << CFG_RX_SEL_LO)
          | (32'(i[1] ? SEL_SEND : SEL_RECEIVE) << CFG_TX_SEL_LO), q, e);
      repeat (40) begin
        @(posedge clock);
        #1;
        chkBit(receivePcmOut, i[0] ? sendPcmIn : receivePcmIn);
        chkBit(sendPcmOut, i[1] ? sendPcmIn : receivePcmIn);
      end
    end
    apb(1'b1, ADDR_CONFIG, 32'h48, q, e);
    repeat (40) begin
      @(posedge clock);
      #1;
      chkBit(sideChannelOut, sideChannelIn);
    end
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_clocks;
    logic [31:0] q;
    logic        e, prev;
    logic [15:0] a, b;
    int          n;
    for (int i = 0; i < 2; i++) begin
      fastClockSelectPin <= i[0];
      repeat (8) @(posedge clock);
      n = 0;
      prev = systemClockOut;
      repeat (64) begin
        @(posedge clock);
        if (systemClockOut !== prev) n++;
        prev = systemClockOut;
      end
      chkBit(i[0] ? (n >= 14) : (n == 0 && systemClockOut === 1'b0), 1'b1);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CONFIG, 32'h40 | (32'(i) << CFG_VCO_INV), q, e);
      @(posedge systemClockIn);
      for (int k = 0; k < 16; k++) begin
        @(posedge clock);
        b[k] = vcoControlOut;
      end
      if (i == 0) a = b;
    end
    chk32({16'h0, b}, {16'h0, ~a});
    $display("test clocks done");
  endtask : t_clocks
  task automatic t_lock;
    logic [31:0] q, al, cf;
    logic        e;
    logic [4:0]  fr;
    for (int i = 0; i < 4; i++) begin
      al = (i == 3) ? 32'h0000_0000 : (i == 1) ? 32'h8000_0500 : (i == 2) ? 32'h0000_0900 : 32'h0000_0500;
      cf = (i == 2) ? 32'hc4 : 32'hc0;
      fr = (i == 3) ? 5'h00 : (i == 1) ? 5'h04 : (i == 2) ? 5'h09 : 5'h05;
      apb(1'b1, ADDR_ALIGN, al, q, e);
      apb(1'b1, ADDR_CONFIG, cf, q, e);
      syncReq <= 1'b1;
      @(posedge clock);
      syncReq <= 1'b0;
      repeat (40) @(posedge clock);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk32(q & 32'h001f_0001, (32'(fr) << ST_FRAME) | 32'h1);
      repeat (60) @(posedge clock);
      chkBit(sideChannelTrackOut, i == 3);
    end
    $display("test lock done");
  endtask : t_lock
  task automatic t_syncout;
    logic [31:0] q;
    logic        e;
    int          n, w;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_CONFIG, 32'h40 | 32'(i), q, e);
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (frameSyncOut_n !== 1'b1 && n < 20);
      do begin
        @(posedge clock);
        n++;
      end while (frameSyncOut_n !== 1'b0 && n < 9000);
      w = 0;
      while (frameSyncOut_n === 1'b0 && w < 40) begin
        @(posedge clock);
        w++;
      end
      chk32(32'(w), i ? 32'd16 : 32'd8);
    end
    while (clockSyncOut === 1'b1) @(posedge clock);
    n = 0;
    while (clockSyncOut !== 1'b1 && n < 9000) begin
      @(posedge clock);
      n++;
    end
    w = 0;
    while (clockSyncOut === 1'b1 && w < 100) begin
      @(posedge clock);
      w++;
    end
    chkBit(w >= 32, 1'b1);
    $display("test sync out done");
  endtask : t_syncout
  task automatic t_fifo;
    logic [31:0] q;
    logic        e;
    apb(1'b1, ADDR_CONFIG, 32'h10, q, e);
    repeat (400) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    chk32(q & 32'h72, 32'h42);
    apb(1'b1, ADDR_CONFIG, 32'h40, q, e);
    repeat (400) @(posedge clock);
    apb(1'b1, ADDR_STATUS, 32'h2, q, e);
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    chk32(q & 32'h72, 32'h0);
    $display("test fifo done");
  endtask : t_fifo
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(60000 * 25);
    nFail++;
    print_verdict();
  end
  initial begin
    nFail = 0;
    compares = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, syncReq, fastClockSelectPin} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_bypass();
    t_clocks();
    t_lock();
    t_syncout();
    t_fifo();
    print_verdict();
  end
endmodule : tb_fsa_align
